/* File: core/cpt_timer.sv */
// Purpose: 32-bit up/down timer with capture and postscaler on APB
// Assumes: One clock pclk at 125 MHz; pins sampled by two flops
// Notes: Zero wait state slave; event lines come from pclk logic
`timescale 1ns/10ps
module cpt_timer (
  input wire logic pclk,
  input wire logic presetn,
  input wire cpt_pkg::cpt_apb_req_s apb_req,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic lposc_pin,
  input wire logic gpio8_pin,
  input wire logic gpio5_pin,
  input wire logic low_power,
  input wire logic [cpt_pkg::EVT_NUM-1:0] irq_events,
  output logic timer_irq
);

  // ----------------------------------------
  // Time format step
  // ----------------------------------------
  // Steps bytes hundredths, seconds, minutes, hours with carry
  function automatic logic [31:0] hms_step(
    input logic [31:0] v,
    input logic up,
    input logic [7:0] hmax
  );
    logic [31:0] r;
    logic c;
    logic [7:0] f;
    logic [7:0] m;
    r = v;
    c = 1'b1;
    for (int i = 0; i < 4; i++) begin
      f = v[8*i +: 8];
      m = (i == 3) ? hmax : ((i == 0) ? cpt_pkg::HUND_MAX : cpt_pkg::MINSEC_MAX);
      if (c) begin
        if (up) begin
          r[8*i +: 8] = (f >= m) ? 8'h00 : f + 8'h01;
          c = (f >= m);
        end else begin
          r[8*i +: 8] = (f == 8'h00) ? m : f - 8'h01;
          c = (f == 8'h00);
        end
      end
    end
    return r;
  endfunction

  // ----------------------------------------
  // State
  // ----------------------------------------
  cpt_pkg::cpt_ctrl_s ctrl_q;
  logic [31:0] load_q;
  logic [31:0] val_q;
  logic [31:0] val_d;
  logic [31:0] cap_q;
  logic [31:0] prdata_q;
  logic [14:0] psc_q;
  logic [7:0] post_cnt_q;
  logic cmp_flag_q;
  logic irq_q;
  logic [2:0] lposc_s;
  logic [2:0] gpio8_s;
  logic [2:0] gpio5_s;
  logic [cpt_pkg::EVT_NUM-1:0] evt_prev_q;

  // ----------------------------------------
  // APB decode
  // ----------------------------------------
  wire setup = apb_req.psel & ~apb_req.penable;
  wire access = apb_req.psel & apb_req.penable;
  wire wr = access & apb_req.pwrite;
  wire hit_load = apb_req.paddr == cpt_pkg::ADDR_LOAD;
  wire hit_value = apb_req.paddr == cpt_pkg::ADDR_VALUE;
  wire hit_ctrl = apb_req.paddr == cpt_pkg::ADDR_CTRL;
  wire hit_clear = apb_req.paddr == cpt_pkg::ADDR_CLEAR;
  wire hit_cap = apb_req.paddr == cpt_pkg::ADDR_CAPTURE;
  wire hit_any = hit_load | hit_value | hit_ctrl | hit_clear | hit_cap;
  wire load_wr = wr & hit_load;
  wire ctrl_wr = wr & hit_ctrl;
  wire clear_wr = wr & hit_clear;

  // Control word as stored; reserved bits and flag are not kept from the bus
  cpt_pkg::cpt_ctrl_s ctrl_wd;
  assign ctrl_wd = {apb_req.pwdata[31:23], 4'h0, apb_req.pwdata[18:0]};

  // Never waits; unmapped addresses answer with an error
  assign pready = 1'b1;
  assign pslverr = access & ~hit_any;
  assign prdata = prdata_q;

  // Control readback shows live postscaler count and flag
  wire [31:0] ctrl_rd = {post_cnt_q, ctrl_q.post_en, 3'h0, cmp_flag_q,
                         ctrl_q[18:0]};

  // Value and capture are readable only; clear reads as zero
  wire [31:0] rd_mux = hit_load ? load_q :
                       hit_value ? val_q :
                       hit_ctrl ? ctrl_rd :
                       hit_cap ? cap_q : 32'h00000000;

  // ----------------------------------------
  // Source synchronisers and edges
  // ----------------------------------------
  // Two flops per pin; third flop only feeds the edge detector
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lposc_s <= 3'h0;
      gpio8_s <= 3'h0;
      gpio5_s <= 3'h0;
    end else begin
      lposc_s <= {lposc_s[1:0], lposc_pin};
      gpio8_s <= {gpio8_s[1:0], gpio8_pin};
      gpio5_s <= {gpio5_s[1:0], gpio5_pin};
    end
  end

  wire lposc_rise = lposc_s[1] & ~lposc_s[2];
  wire gpio8_rise = gpio8_s[1] & ~gpio8_s[2];
  wire gpio5_rise = gpio5_s[1] & ~gpio5_s[2];

  // Core source stops in low power; the others keep ticking
  wire src_tick = (ctrl_q.clk_sel == cpt_pkg::SRC_CORE) ? ~low_power :
                  (ctrl_q.clk_sel == cpt_pkg::SRC_LPOSC) ? lposc_rise :
                  (ctrl_q.clk_sel == cpt_pkg::SRC_GPIO8) ? gpio8_rise :
                  (ctrl_q.clk_sel == cpt_pkg::SRC_GPIO5) ? gpio5_rise : 1'b0;

  // ----------------------------------------
  // Prescaler
  // ----------------------------------------
  // Unlisted codes divide by one
  wire [14:0] psc_tc = (ctrl_q.presc == cpt_pkg::PSC_DIV16) ? cpt_pkg::PSC_TC16 :
                       (ctrl_q.presc == cpt_pkg::PSC_DIV256) ? cpt_pkg::PSC_TC256 :
                       (ctrl_q.presc == cpt_pkg::PSC_DIV32K) ? cpt_pkg::PSC_TC32K :
                       cpt_pkg::PSC_TC1;
  wire run = ctrl_q.enable;
  wire psc_wrap = src_tick & (psc_q >= psc_tc);
  wire cnt_tick = run & psc_wrap;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      psc_q <= 15'h0000;
    end else if (!run || ctrl_wr) begin
      psc_q <= 15'h0000;
    end else if (src_tick) begin
      psc_q <= psc_wrap ? 15'h0000 : psc_q + 15'h0001;
    end
  end

  // ----------------------------------------
  // Counter
  // ----------------------------------------
  wire up = ctrl_q.count_up;
  wire hms = (ctrl_q.fmt == cpt_pkg::FMT_HMS23) | (ctrl_q.fmt == cpt_pkg::FMT_HMS255);
  wire [7:0] hmax = (ctrl_q.fmt == cpt_pkg::FMT_HMS23) ? cpt_pkg::HOURS_MAX23 :
                    cpt_pkg::HOURS_MAX255;
  wire [31:0] full = hms ? {hmax, cpt_pkg::MINSEC_MAX, cpt_pkg::MINSEC_MAX,
                            cpt_pkg::HUND_MAX} : 32'hffffffff;
  wire at_term = up ? (val_q == full) : (val_q == 32'h00000000);
  wire timeout = cnt_tick & at_term;

  // Periodic restarts from load; free-running from min or max
  wire [31:0] start = ctrl_q.periodic ? load_q :
                      (up ? 32'h00000000 : full);

  // A control write restarts from the start value of the mode being written
  wire wd_hms = (ctrl_wd.fmt == cpt_pkg::FMT_HMS23) | (ctrl_wd.fmt == cpt_pkg::FMT_HMS255);
  wire [7:0] wd_hmax = (ctrl_wd.fmt == cpt_pkg::FMT_HMS23) ? cpt_pkg::HOURS_MAX23 :
                       cpt_pkg::HOURS_MAX255;
  wire [31:0] wd_full = wd_hms ? {wd_hmax, cpt_pkg::MINSEC_MAX, cpt_pkg::MINSEC_MAX,
                                  cpt_pkg::HUND_MAX} : 32'hffffffff;
  wire [31:0] wd_start = ctrl_wd.periodic ? load_q :
                         (ctrl_wd.count_up ? 32'h00000000 : wd_full);

  // One count step in the chosen direction, binary or time format
  wire [31:0] step = hms ? hms_step(val_q, up, hmax) :
                     (up ? val_q + 32'h00000001 : val_q - 32'h00000001);

  // Next counter value
  always_comb begin
    val_d = val_q;
    if (ctrl_wr) begin
      val_d = wd_start;
    end else if (cnt_tick) begin
      val_d = at_term ? start : step;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      val_q <= cpt_pkg::VALUE_RST;
    end else begin
      val_q <= val_d;
    end
  end

  // ----------------------------------------
  // Postscaler
  // ----------------------------------------
  wire [7:0] post_tgt = (ctrl_q.post_target == 8'h00) ? 8'h01 :
                        ctrl_q.post_target;
  wire post_step = ctrl_q.post_en & timeout;
  wire post_hit = post_step & ((post_cnt_q + 8'h01) == post_tgt);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      post_cnt_q <= 8'h00;
    end else if (ctrl_wr || post_hit) begin
      post_cnt_q <= 8'h00;
    end else if (post_step) begin
      post_cnt_q <= post_cnt_q + 8'h01;
    end
  end

  // ----------------------------------------
  // Flag and interrupt
  // ----------------------------------------
  wire irq_set = ctrl_q.irq_post ? post_hit : timeout;

  // Setting wins over a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmp_flag_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      cmp_flag_q <= post_hit | (cmp_flag_q & ~clear_wr);
      irq_q <= irq_set | (irq_q & ~clear_wr);
    end
  end

  assign timer_irq = irq_q;

  // ----------------------------------------
  // Event capture
  // ----------------------------------------
  wire sel_ok = ctrl_q.cap_sel <= cpt_pkg::EVT_LAST;
  wire evt_now = sel_ok & irq_events[ctrl_q.cap_sel];
  wire evt_was = sel_ok & evt_prev_q[ctrl_q.cap_sel];
  wire cap_fire = ctrl_q.cap_en & evt_now & ~evt_was;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt_prev_q <= '0;
      cap_q <= cpt_pkg::CAPTURE_RST;
    end else begin
      evt_prev_q <= irq_events;
      if (cap_fire) begin
        cap_q <= val_q;
      end
    end
  end

  // ----------------------------------------
  // Register writes and read data
  // ----------------------------------------
  // Reserved bits and flag are not stored from the bus
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= cpt_pkg::CTRL_RST;
      load_q <= cpt_pkg::LOAD_RST;
    end else begin
      if (ctrl_wr) begin
        ctrl_q <= ctrl_wd;
      end
      if (load_wr) begin
        load_q <= apb_req.pwdata;
      end
    end
  end

  // Read data sampled in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h00000000;
    end else if (setup) begin
      prdata_q <= apb_req.pwrite ? 32'h00000000 : rd_mux;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_irq_clear: assert property (
    clear_wr && !irq_set |=> !timer_irq)
    else $error("Interrupt not cleared by clear write");

  chk_irq_direct: assert property (
    timeout && !ctrl_q.irq_post |=> timer_irq)
    else $error("Timeout did not raise interrupt");

  chk_cap_copy: assert property (
    cap_fire |=> cap_q == $past(val_q))
    else $error("Capture did not hold counter value");

  chk_cap_once: assert property (
    evt_now && evt_was && !ctrl_wr |=> $stable(cap_q))
    else $error("Held event captured again");

  chk_stop_hold: assert property (
    !ctrl_q.enable && !ctrl_wr |=> $stable(val_q))
    else $error("Counter moved while stopped");

  chk_down_step: assert property (
    cnt_tick && !up && !hms && !at_term && !ctrl_wr
    |=> val_q == $past(val_q) - 32'h00000001)
    else $error("Down count step wrong");

  chk_reload_load: assert property (
    timeout && ctrl_q.periodic && !ctrl_wr |=> val_q == $past(load_q))
    else $error("Periodic reload missed");

  chk_post_flag: assert property (
    post_hit |=> cmp_flag_q ##1 cmp_flag_q || $past(clear_wr))
    else $error("Compare flag not set on target");

  chk_post_zero: assert property (
    post_step && ctrl_q.post_target == 8'h00 |=> post_cnt_q == 8'h00)
    else $error("Zero target not treated as one");

  chk_ctrl_read: assert property (
    setup && !apb_req.pwrite && hit_ctrl
    |=> prdata[31:24] == $past(post_cnt_q))
    else $error("Control read lacks postscaler count");

  chk_up_step: assert property (
    cnt_tick && up && !hms && !at_term && !ctrl_wr
    |=> val_q == $past(val_q) + 32'h00000001)
    else $error("Up count step wrong");

  chk_free_reload: assert property (
    timeout && !ctrl_q.periodic && !up && !hms && !ctrl_wr |=> val_q == 32'hffffffff)
    else $error("Free-running reload missed");

  chk_restart_wr: assert property (
    ctrl_wr && ctrl_wd.periodic |=> val_q == $past(load_q))
    else $error("Control write did not restart from load");

  chk_lp_hold: assert property (
    low_power && ctrl_q.clk_sel == cpt_pkg::SRC_CORE && !ctrl_wr |=> $stable(val_q))
    else $error("Core source counted in low-power mode");

  chk_post_count: assert property (
    post_step && !post_hit && !ctrl_wr |=> post_cnt_q == $past(post_cnt_q) + 8'h01)
    else $error("Postscaler did not count timeout");

  chk_cap_idle: assert property (
    !ctrl_q.cap_en |=> $stable(cap_q))
    else $error("Capture changed while disarmed");

  chk_irq_hold: assert property (
    timer_irq && !clear_wr |=> timer_irq)
    else $error("Interrupt dropped without clear");

endmodule

/* File: core/cpt_pkg.sv */
// Purpose: Shared constants and types of the capture postscale timer
// Assumes: APB with 32-bit data, one word per register
// Notes: Offsets are full byte addresses
package cpt_pkg;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [31:0] ADDR_LOAD = 32'hffff0320;
  localparam logic [31:0] ADDR_VALUE = 32'hffff0324;
  localparam logic [31:0] ADDR_CTRL = 32'hffff0328;
  localparam logic [31:0] ADDR_CLEAR = 32'hffff032c;
  localparam logic [31:0] ADDR_CAPTURE = 32'hffff0330;

  // ----------------------------------------
  // Values after reset
  // ----------------------------------------
  localparam logic [31:0] LOAD_RST = 32'h00000000;
  localparam logic [31:0] VALUE_RST = 32'h0fffffff;
  localparam logic [31:0] CTRL_RST = 32'h01000000;
  localparam logic [31:0] CAPTURE_RST = 32'h00000000;

  // ----------------------------------------
  // Field codes
  // ----------------------------------------
  localparam logic [2:0] SRC_CORE = 3'h0;
  localparam logic [2:0] SRC_LPOSC = 3'h1;
  localparam logic [2:0] SRC_GPIO8 = 3'h2;
  localparam logic [2:0] SRC_GPIO5 = 3'h3;
  localparam logic [3:0] PSC_DIV16 = 4'h4;
  localparam logic [3:0] PSC_DIV256 = 4'h8;
  localparam logic [3:0] PSC_DIV32K = 4'hf;
  localparam logic [1:0] FMT_HMS23 = 2'h2;
  localparam logic [1:0] FMT_HMS255 = 2'h3;
  localparam logic [4:0] EVT_LAST = 5'h11;
  localparam int EVT_NUM = 18;

  // ----------------------------------------
  // Prescaler terminal counts (divisor less one)
  // ----------------------------------------
  localparam logic [14:0] PSC_TC1 = 15'h0000;
  localparam logic [14:0] PSC_TC16 = 15'h000f;
  localparam logic [14:0] PSC_TC256 = 15'h00ff;
  localparam logic [14:0] PSC_TC32K = 15'h7fff;

  // ----------------------------------------
  // Time format limits, one byte per field
  // ----------------------------------------
  localparam logic [7:0] HUND_MAX = 8'h63;
  localparam logic [7:0] MINSEC_MAX = 8'h3b;
  localparam logic [7:0] HOURS_MAX23 = 8'h17;
  localparam logic [7:0] HOURS_MAX255 = 8'hff;

  // Control register layout
  typedef struct packed {
    logic [7:0] post_target;
    logic post_en;
    logic [2:0] rsvd;
    logic cmp_flag;
    logic irq_post;
    logic cap_en;
    logic [4:0] cap_sel;
    logic [2:0] clk_sel;
    logic count_up;
    logic enable;
    logic periodic;
    logic [1:0] fmt;
    logic [3:0] presc;
  } cpt_ctrl_s;

  // APB request from the master
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
  } cpt_apb_req_s;

endpackage

/* File: verification/tb.sv */
// Purpose: Self-checking bench for the capture postscale timer
// Assumes: Zero wait state APB slave, core source divides by one
// Notes: Each scenario drives the ports and judges the result itself
`timescale 1ns/10ps
module tb;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  cpt_pkg::cpt_apb_req_s req = '0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic lposc_pin = 1'b0;
  logic gpio8_pin = 1'b0;
  logic gpio5_pin = 1'b0;
  logic low_power = 1'b0;
  logic [17:0] irq_events = '0;
  logic timer_irq;
  logic [31:0] rdat;
  logic rerr;
  int err_total = 0;
  int compares = 0;

  // ----------------------------------------
  // Clock, device and watchdog
  // ----------------------------------------
  always #4 pclk = ~pclk;

  cpt_timer dut_u (
    .pclk(pclk),
    .presetn(presetn),
    .apb_req(req),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .lposc_pin(lposc_pin),
    .gpio8_pin(gpio8_pin),
    .gpio5_pin(gpio5_pin),
    .low_power(low_power),
    .irq_events(irq_events),
    .timer_irq(timer_irq)
  );

  // Cuts a hang short
  initial begin
    #100000;
    err_total++;
    end_sim();
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic end_sim();
    $display("errors %0d compares %0d", err_total, compares);
    if (err_total == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // One APB transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    req.psel <= 1'b1;
    req.penable <= 1'b0;
    req.pwrite <= w;
    req.paddr <= a;
    req.pwdata <= d;
    @(posedge pclk);
    req.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 40);
    if (n >= 40) err_total++;
    rdat = prdata;
    rerr = pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask

  // Counts settled cycles until the interrupt shows
  task automatic wirq(input int lim, output int n);
    n = 0;
    while (timer_irq !== 1'b1 && n < lim) begin
      @(negedge pclk);
      n++;
    end
  endtask

  // Stops the timer so no stale timeout survives the clear, then load before control
  task automatic start(input logic [31:0] ld, input logic [31:0] ctl);
    apb(1'b1, cpt_pkg::ADDR_CTRL, 32'h00000000);
    apb(1'b1, cpt_pkg::ADDR_CLEAR, 32'h0000005a);
    apb(1'b1, cpt_pkg::ADDR_LOAD, ld);
    apb(1'b1, cpt_pkg::ADDR_CTRL, ctl & 32'hff8fffff);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    apb(1'b0, cpt_pkg::ADDR_VALUE, 32'h0);
    chk(rdat, 32'h0fffffff);
    apb(1'b0, cpt_pkg::ADDR_CTRL, 32'h0);
    chk(rdat, {8'h00, cpt_pkg::CTRL_RST[23:0]});
    apb(1'b0, cpt_pkg::ADDR_CAPTURE, 32'h0);
    chk(rdat, 32'h00000000);
    apb(1'b0, 32'hffff0334, 32'h0);
    chk({31'h0, rerr}, 32'h1);
  endtask

  // Stopped periodic counter holds the load value; value ignores writes
  task automatic t_stop();
    start(32'h00000007, 32'h00000040);
    apb(1'b1, cpt_pkg::ADDR_VALUE, 32'h00000000);
    repeat (4) @(posedge pclk);
    apb(1'b0, cpt_pkg::ADDR_VALUE, 32'h0);
    chk(rdat, 32'h00000007);
  endtask

  task automatic t_down();
    int n;
    start(32'h00000003, 32'h000000c0);
    wirq(20, n);
    chk({31'h0, n >= 3 && n <= 8}, 32'h1);
    apb(1'b0, cpt_pkg::ADDR_VALUE, 32'h0);
    chk({31'h0, rdat <= 32'h3}, 32'h1);
    apb(1'b1, cpt_pkg::ADDR_CLEAR, 32'h000000ff);
    @(negedge pclk);
    chk({31'h0, timer_irq}, 32'h0);
  endtask

  task automatic t_up();
    int n;
    start(32'hfffffffd, 32'h000001c0);
    wirq(20, n);
    chk({31'h0, timer_irq}, 32'h1);
    chk(n, 32'h00000004);
    apb(1'b0, cpt_pkg::ADDR_VALUE, 32'h0);
    chk(rdat >> 2, 32'h3fffffff);
  endtask

  task automatic t_capture();
    start(32'h00001234, 32'h000250c0);
    @(posedge pclk);
    irq_events[5] <= 1'b1;
    repeat (3) @(posedge pclk);
    irq_events[5] <= 1'b0;
    apb(1'b0, cpt_pkg::ADDR_CAPTURE, 32'h0);
    chk(rdat, 32'h00001233);
    apb(1'b0, cpt_pkg::ADDR_VALUE, 32'h0);
    chk(rdat, 32'h0000122c);
  endtask

  task automatic t_post();
    int n;
    start(32'h00000001, 32'h038400c0);
    repeat (3) @(negedge pclk);
    chk({31'h0, timer_irq}, 32'h0);
    wirq(30, n);
    chk({31'h0, timer_irq}, 32'h1);
    apb(1'b0, cpt_pkg::ADDR_CTRL, 32'h0);
    chk({31'h0, rdat[19]}, 32'h1);
    chk({31'h0, rdat[31:24] < 8'h03}, 32'h1);
    start(32'h00000001, 32'h008400c0);
    wirq(8, n);
    chk({31'h0, timer_irq}, 32'h1);
  endtask

  task automatic t_presc();
    int n;
    start(32'h00000002, 32'h000000c4);
    wirq(80, n);
    chk({31'h0, n >= 40 && n <= 56}, 32'h1);
  endtask

  task automatic t_time();
    start(32'h00000062, 32'h000001e0);
    repeat (3) @(posedge pclk);
    apb(1'b0, cpt_pkg::ADDR_VALUE, 32'h0);
    chk(rdat >> 8, 32'h00000001);
  endtask

  // Each pin source steps once per rising edge in low-power mode; core source stops
  task automatic t_gpio();
    low_power <= 1'b1;
    for (int s = 1; s < 4; s++) begin
      start(32'h0000000a, {20'h00000, s[2:0], 9'h0c0});
      repeat (4) begin
        repeat (3) @(posedge pclk);
        lposc_pin <= (s == 1);
        gpio8_pin <= (s == 2);
        gpio5_pin <= (s == 3);
        repeat (3) @(posedge pclk);
        lposc_pin <= 1'b0;
        gpio8_pin <= 1'b0;
        gpio5_pin <= 1'b0;
      end
      repeat (5) @(posedge pclk);
      apb(1'b0, cpt_pkg::ADDR_VALUE, 32'h0);
      chk(rdat, 32'h00000006);
    end
    start(32'h0000000a, 32'h000000c0);
    repeat (4) @(posedge pclk);
    apb(1'b0, cpt_pkg::ADDR_VALUE, 32'h0);
    chk(rdat, 32'h0000000a);
    low_power <= 1'b0;
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_stop();
    t_down();
    t_up();
    t_capture();
    t_post();
    t_presc();
    t_time();
    t_gpio();
    end_sim();
  end
endmodule
